// File: hw/status_addr.sv
// status word, parity and operand address formation for the cpu core
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - parity set when accumulator ones count odd
// - parity recomputed each cycle, writes ignored
// - status word bit layout carry to parity
// - bank value picks one of four ram octets
// - bank taken at execution, not fetch
// - bank bits software readable and writable
// - user flag zero is plain storage
// - carry doubles as boolean accumulator
// - direct reaches low 128 ram or sfr
// - byte indirect via pointer zero/one or stack
// - word indirect only via data pointer
// - indirect reaches internal and external ram
// - three opcode bits pick bank register
// - register specific opcodes imply operand
// - immediate bytes follow opcode in code
// - indexed is code read only
// - indexed address is base plus accumulator
// - case jump target is base plus accumulator
module status_addr (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [7:0] ACC,
    input wire logic [15:0] DATA_POINTER,
    input wire logic [15:0] PROG_COUNTER,
    input wire logic [7:0] STACK_POINTER,
    input wire logic PSW_WR,
    input wire logic [7:0] PSW_WDATA,
    input wire status_addr_pkg::flag_upd_s FLAG_UPD,
    input wire logic BOOL_CARRY_WR,
    input wire logic BOOL_CARRY,
    input wire status_addr_pkg::addr_req_s ADDR_REQ,
    output logic [7:0] PROGRAM_STATUS_WORD,
    output logic [1:0] BANK,
    output status_addr_pkg::addr_resp_s ADDR_RESP
);

    // ****************************************************
    // status word state
    // ****************************************************
    logic carry_q;
    logic carry_d;
    logic half_carry_q;
    logic half_carry_d;
    logic user_flag_q;
    logic user_flag_d;
    logic [1:0] bank_q;
    logic [1:0] bank_d;
    logic overflow_q;
    logic overflow_d;
    logic parity_q;
    logic parity_d;

    // ****************************************************
    // carry flag
    // ****************************************************
    // hardware update wins over a software write in the same cycle
    always_comb begin
        carry_d = carry_q;
        if (PSW_WR) begin
            carry_d = PSW_WDATA[status_addr_pkg::CARRY_BIT];
        end
        if (FLAG_UPD.wr_carry) begin
            carry_d = FLAG_UPD.carry;
        end
        if (BOOL_CARRY_WR) begin
            carry_d = BOOL_CARRY;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            carry_q <= status_addr_pkg::PSW_RESET[status_addr_pkg::CARRY_BIT];
        end else begin
            carry_q <= carry_d;
        end
    end

    // ****************************************************
    // half carry flag
    // ****************************************************
    always_comb begin
        half_carry_d = half_carry_q;
        if (PSW_WR) begin
            half_carry_d = PSW_WDATA[status_addr_pkg::HALF_CARRY_BIT];
        end
        if (FLAG_UPD.wr_half_carry) begin
            half_carry_d = FLAG_UPD.half_carry;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            half_carry_q <=
                status_addr_pkg::PSW_RESET[status_addr_pkg::HALF_CARRY_BIT];
        end else begin
            half_carry_q <= half_carry_d;
        end
    end

    // ****************************************************
    // overflow flag
    // ****************************************************
    always_comb begin
        overflow_d = overflow_q;
        if (PSW_WR) begin
            overflow_d = PSW_WDATA[status_addr_pkg::OVERFLOW_BIT];
        end
        if (FLAG_UPD.wr_overflow) begin
            overflow_d = FLAG_UPD.overflow;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            overflow_q <=
                status_addr_pkg::PSW_RESET[status_addr_pkg::OVERFLOW_BIT];
        end else begin
            overflow_q <= overflow_d;
        end
    end

    // ****************************************************
    // user flag, software only
    // ****************************************************
    // no hardware source: plain storage bit
    always_comb begin
        user_flag_d = user_flag_q;
        if (PSW_WR) begin
            user_flag_d = PSW_WDATA[status_addr_pkg::USER_FLAG_BIT];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            user_flag_q <=
                status_addr_pkg::PSW_RESET[status_addr_pkg::USER_FLAG_BIT];
        end else begin
            user_flag_q <= user_flag_d;
        end
    end

    // ****************************************************
    // bank select, software only
    // ****************************************************
    // a write takes effect from the next request on
    always_comb begin
        bank_d = bank_q;
        if (PSW_WR) begin
            bank_d = {PSW_WDATA[status_addr_pkg::BANK_HIGH_BIT],
                      PSW_WDATA[status_addr_pkg::BANK_LOW_BIT]};
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            bank_q <= {
                status_addr_pkg::PSW_RESET[status_addr_pkg::BANK_HIGH_BIT],
                status_addr_pkg::PSW_RESET[status_addr_pkg::BANK_LOW_BIT]};
        end else begin
            bank_q <= bank_d;
        end
    end

    // ****************************************************
    // parity
    // ****************************************************
    // running xor over the accumulator, one stage per bit
    logic [8:0] parity_chain;

    assign parity_chain[0] = 1'b0;

    generate
        for (genvar i = 0; i < 8; i++) begin : g_parity
            assign parity_chain[i + 1] = parity_chain[i] ^ ACC[i];
        end
    endgenerate

    // every clock, so a software write to the bit never sticks
    assign parity_d = parity_chain[8];

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            parity_q <= status_addr_pkg::PSW_RESET[status_addr_pkg::PARITY_BIT];
        end else begin
            parity_q <= parity_d;
        end
    end

    // ****************************************************
    // status word read view
    // ****************************************************
    logic [7:0] psw_d;

    always_comb begin
        psw_d = 8'h00;
        psw_d[status_addr_pkg::CARRY_BIT] = carry_d;
        psw_d[status_addr_pkg::HALF_CARRY_BIT] = half_carry_d;
        psw_d[status_addr_pkg::USER_FLAG_BIT] = user_flag_d;
        psw_d[status_addr_pkg::BANK_HIGH_BIT] = bank_d[1];
        psw_d[status_addr_pkg::BANK_LOW_BIT] = bank_d[0];
        psw_d[status_addr_pkg::OVERFLOW_BIT] = overflow_d;
        psw_d[status_addr_pkg::RESERVED_BIT] = 1'b0;
        psw_d[status_addr_pkg::PARITY_BIT] = parity_d;
    end

    // parity reads zero while in reset
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            PROGRAM_STATUS_WORD <= {status_addr_pkg::PSW_RESET[7:1], 1'b0};
        end else begin
            PROGRAM_STATUS_WORD <= psw_d;
        end
    end

    // copy of the bank bits for the register file
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            BANK <= {
                status_addr_pkg::PSW_RESET[status_addr_pkg::BANK_HIGH_BIT],
                status_addr_pkg::PSW_RESET[status_addr_pkg::BANK_LOW_BIT]};
        end else begin
            BANK <= bank_d;
        end
    end

    // ****************************************************
    // operand address formation
    // ****************************************************
    status_addr_pkg::addr_resp_s resp_d;
    logic [7:0] bank_base;
    logic [15:0] acc_ext;
    logic [7:0] reg_addr;
    logic [7:0] byte_ptr_addr;
    logic [15:0] data_pointer_index_sum;
    logic [15:0] pc_index_sum;
    logic direct_is_ram;

    // live bank bits at the moment the request executes
    assign bank_base = {3'h0, bank_q, {status_addr_pkg::BANK_SIZE_LOG2{1'b0}}};
    assign acc_ext = {8'h00, ACC};
    assign reg_addr = bank_base | {5'h00, ADDR_REQ.opcode[2:0]};

    // table reads wrap at the top of code space
    assign data_pointer_index_sum = DATA_POINTER + acc_ext;
    assign pc_index_sum = PROG_COUNTER + acc_ext;

    // only the low half of the direct range is ram
    assign direct_is_ram = ADDR_REQ.field < status_addr_pkg::DIRECT_RAM_LIMIT;

    // pointer register zero or one, or the stack pointer
    always_comb begin
        if (ADDR_REQ.ptr_sel == status_addr_pkg::PTR_SEL_STACK) begin
            byte_ptr_addr = STACK_POINTER;
        end else begin
            byte_ptr_addr = ADDR_REQ.ptr_value;
        end
    end

    always_comb begin
        resp_d = '0;
        resp_d.valid = ADDR_REQ.valid;
        resp_d.write = ADDR_REQ.write;
        case (ADDR_REQ.mode)
            status_addr_pkg::MODE_DIRECT: begin
                resp_d.addr = {8'h00, ADDR_REQ.field};
                if (direct_is_ram) begin
                    resp_d.space = status_addr_pkg::SPACE_INT_RAM;
                end else begin
                    resp_d.space = status_addr_pkg::SPACE_SFR;
                end
            end
            status_addr_pkg::MODE_INDIRECT8: begin
                resp_d.addr = {8'h00, byte_ptr_addr};
                if (ADDR_REQ.external) begin
                    resp_d.space = status_addr_pkg::SPACE_EXT_RAM;
                end else begin
                    resp_d.space = status_addr_pkg::SPACE_INT_RAM;
                end
            end
            status_addr_pkg::MODE_INDIRECT16: begin
                resp_d.addr = DATA_POINTER;
                resp_d.space = status_addr_pkg::SPACE_EXT_RAM;
            end
            status_addr_pkg::MODE_REGISTER: begin
                resp_d.addr = {8'h00, reg_addr};
                resp_d.space = status_addr_pkg::SPACE_INT_RAM;
            end
            status_addr_pkg::MODE_REG_SPECIFIC: begin
                resp_d.addr = {8'h00, ADDR_REQ.opcode};
                resp_d.space = status_addr_pkg::SPACE_IMPLIED;
            end
            status_addr_pkg::MODE_IMMEDIATE: begin
                resp_d.addr = PROG_COUNTER;
                resp_d.space = status_addr_pkg::SPACE_CODE;
                resp_d.refused = ADDR_REQ.write;
                resp_d.write = 1'b0;
            end
            status_addr_pkg::MODE_INDEX_DATA_POINTER: begin
                resp_d.addr = data_pointer_index_sum;
                resp_d.space = status_addr_pkg::SPACE_CODE;
                resp_d.refused = ADDR_REQ.write;
                resp_d.write = 1'b0;
            end
            status_addr_pkg::MODE_INDEX_PC: begin
                resp_d.addr = pc_index_sum;
                resp_d.space = status_addr_pkg::SPACE_CODE;
                resp_d.refused = ADDR_REQ.write;
                resp_d.write = 1'b0;
            end
            status_addr_pkg::MODE_CASE_JUMP: begin
                resp_d.addr = data_pointer_index_sum;
                resp_d.space = status_addr_pkg::SPACE_CODE;
                resp_d.jump = 1'b1;
                resp_d.write = 1'b0;
            end
            default: begin
                resp_d.space = status_addr_pkg::SPACE_NONE;
                resp_d.refused = ADDR_REQ.valid;
                resp_d.write = 1'b0;
            end
        endcase
        if (!ADDR_REQ.valid) begin
            resp_d = '0;
        end
    end

    // ****************************************************
    // response register
    // ****************************************************
    // one cycle per request, follows the request inputs
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ADDR_RESP <= '0;
        end else begin
            ADDR_RESP <= resp_d;
        end
    end

endmodule : status_addr

`default_nettype wire

// File: hw/status_addr_pkg.sv
// shared constants and types for status word and operand addressing
package status_addr_pkg;

    // ****************************************************
    // status word layout
    // ****************************************************
    localparam int CARRY_BIT = 7;
    localparam int HALF_CARRY_BIT = 6;
    localparam int USER_FLAG_BIT = 5;
    localparam int BANK_HIGH_BIT = 4;
    localparam int BANK_LOW_BIT = 3;
    localparam int OVERFLOW_BIT = 2;
    localparam int RESERVED_BIT = 1;
    localparam int PARITY_BIT = 0;
    localparam logic [7:0] PSW_RESET = 8'h00;
    // bits software may store; parity and reserved excluded
    localparam logic [7:0] PSW_SW_MASK = 8'hFC;

    // ****************************************************
    // address space limits
    // ****************************************************
    localparam logic [7:0] DIRECT_RAM_LIMIT = 8'h80;
    localparam int BANK_SIZE_LOG2 = 3;

    // ****************************************************
    // enumerations
    // ****************************************************
    typedef enum logic [3:0] {
        MODE_DIRECT,
        MODE_INDIRECT8,
        MODE_INDIRECT16,
        MODE_REGISTER,
        MODE_REG_SPECIFIC,
        MODE_IMMEDIATE,
        MODE_INDEX_DATA_POINTER,
        MODE_INDEX_PC,
        MODE_CASE_JUMP
    } addr_mode_e;

    typedef enum logic [1:0] {
        PTR_SEL_REG_ZERO,
        PTR_SEL_REG_ONE,
        PTR_SEL_STACK
    } ptr_sel_e;

    typedef enum logic [2:0] {
        SPACE_NONE,
        SPACE_INT_RAM,
        SPACE_SFR,
        SPACE_EXT_RAM,
        SPACE_CODE,
        SPACE_IMPLIED
    } space_e;

    // ****************************************************
    // carriers
    // ****************************************************
    typedef struct packed {
        logic valid;
        addr_mode_e mode;
        logic write;
        logic external;
        ptr_sel_e ptr_sel;
        logic [7:0] opcode;
        logic [7:0] field;
        logic [7:0] ptr_value;
    } addr_req_s;

    typedef struct packed {
        logic valid;
        space_e space;
        logic [15:0] addr;
        logic write;
        logic refused;
        logic jump;
    } addr_resp_s;

    typedef struct packed {
        logic wr_carry;
        logic carry;
        logic wr_half_carry;
        logic half_carry;
        logic wr_overflow;
        logic overflow;
    } flag_upd_s;

endpackage : status_addr_pkg

// File: tb/status_addr_checker.sv
// port assertions for the status word and address block
`timescale 1ns/1ps
`default_nettype none
module status_addr_checker (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [7:0] ACC,
    input wire logic [15:0] DATA_POINTER,
    input wire logic PSW_WR,
    input wire logic [7:0] PSW_WDATA,
    input wire status_addr_pkg::flag_upd_s FLAG_UPD,
    input wire logic BOOL_CARRY_WR,
    input wire logic BOOL_CARRY,
    input wire status_addr_pkg::addr_req_s ADDR_REQ,
    input wire logic [7:0] PROGRAM_STATUS_WORD,
    input wire logic [1:0] BANK,
    input wire status_addr_pkg::addr_resp_s ADDR_RESP
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    wire logic [2:0] reg_sel = ADDR_REQ.opcode[2:0];
    wire logic [15:0] idx_sum = DATA_POINTER + 16'(ACC);
    wire logic quiet = !PSW_WR && FLAG_UPD == '0 && !BOOL_CARRY_WR;
    wire logic sw_only = PSW_WR && FLAG_UPD == '0 && !BOOL_CARRY_WR;
    property p_par;
        !$past(RESET) |-> PROGRAM_STATUS_WORD[0] == ^$past(ACC);
    endproperty
    a_par: assert property (p_par) else $error("parity stale");
    property p_rsv;
        PROGRAM_STATUS_WORD[1] == 1'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_bank;
        BANK == PROGRAM_STATUS_WORD[4:3];
    endproperty
    a_bank: assert property (p_bank) else $error("bank mismatch");
    property p_sw;
        sw_only |=> (PROGRAM_STATUS_WORD & 8'hFC) == ($past(PSW_WDATA) & 8'hFC);
    endproperty
    a_sw: assert property (p_sw) else $error("write lost");
    property p_hold;
        quiet |=> $stable(PROGRAM_STATUS_WORD[7:2]);
    endproperty
    a_hold: assert property (p_hold) else $error("flags drifted");
    property p_bool;
        BOOL_CARRY_WR |=> PROGRAM_STATUS_WORD[7] == $past(BOOL_CARRY);
    endproperty
    a_bool: assert property (p_bool) else $error("carry not set");
    property p_reg;
        ADDR_REQ.valid && ADDR_REQ.mode == status_addr_pkg::MODE_REGISTER
        |=> ADDR_RESP.addr == {11'h000, $past(BANK), $past(reg_sel)};
    endproperty
    a_reg: assert property (p_reg) else $error("bad reg addr");
    property p_idx;
        ADDR_REQ.valid && ADDR_REQ.mode == status_addr_pkg::MODE_INDEX_DATA_POINTER
        && !ADDR_REQ.write |=> ADDR_RESP.addr == $past(idx_sum)
        && ADDR_RESP.space == status_addr_pkg::SPACE_CODE;
    endproperty
    a_idx: assert property (p_idx) else $error("bad index addr");
    property p_ref;
        ADDR_REQ.valid && ADDR_REQ.write
        && ADDR_REQ.mode == status_addr_pkg::MODE_INDEX_PC
        |=> ADDR_RESP.valid && ADDR_RESP.refused && !ADDR_RESP.write;
    endproperty
    a_ref: assert property (p_ref) else $error("index write kept");
endmodule : status_addr_checker
`default_nettype wire

// File: tb/tb_status_addr.sv
// table and directed tests for the status word and address block
`timescale 1ns/1ps
`default_nettype none
module tb_status_addr;
    // md: mode code, sp: space code, both in enum order
    typedef struct packed {
        logic [3:0] md;
        logic wr, ex;
        logic [1:0] ps;
        logic [7:0] op, fd, pv;
        logic [2:0] sp;
        logic [15:0] ad;
        logic rf, jp;
    } row_s;
    logic SYS_CLK, RESET, PSW_WR, BOOL_CARRY_WR, BOOL_CARRY;
    logic [7:0] ACC, STACK_POINTER, PSW_WDATA, PROGRAM_STATUS_WORD;
    logic [15:0] DATA_POINTER, PROG_COUNTER;
    logic [1:0] BANK;
    status_addr_pkg::flag_upd_s FLAG_UPD;
    status_addr_pkg::addr_req_s ADDR_REQ;
    status_addr_pkg::addr_resp_s ADDR_RESP;
    int fail_count = 0;
    int n_checks = 0;
    row_s q;
    row_s rows [15] = '{
        '{4'h0,1'h1,1'h0,2'h0,8'h00,8'h7F,8'h00,3'h1,16'h007F,1'h0,1'h0},
        '{4'h0,1'h0,1'h0,2'h0,8'h00,8'h80,8'h00,3'h2,16'h0080,1'h0,1'h0},
        '{4'h1,1'h0,1'h0,2'h0,8'h00,8'h00,8'h33,3'h1,16'h0033,1'h0,1'h0},
        '{4'h1,1'h0,1'h0,2'h2,8'h00,8'h00,8'h33,3'h1,16'h0047,1'h0,1'h0},
        '{4'h1,1'h1,1'h1,2'h1,8'h00,8'h00,8'h99,3'h3,16'h0099,1'h0,1'h0},
        '{4'h2,1'h0,1'h1,2'h0,8'h00,8'h00,8'h00,3'h3,16'h1234,1'h0,1'h0},
        '{4'h3,1'h0,1'h0,2'h0,8'hEF,8'h00,8'h00,3'h1,16'h0017,1'h0,1'h0},
        '{4'h4,1'h0,1'h0,2'h0,8'hE4,8'h00,8'h00,3'h5,16'h00E4,1'h0,1'h0},
        '{4'h5,1'h0,1'h0,2'h0,8'h00,8'h00,8'h00,3'h4,16'h2000,1'h0,1'h0},
        '{4'h5,1'h1,1'h0,2'h0,8'h00,8'h00,8'h00,3'h4,16'h2000,1'h1,1'h0},
        '{4'h6,1'h0,1'h0,2'h0,8'h00,8'h00,8'h00,3'h4,16'h1324,1'h0,1'h0},
        '{4'h7,1'h0,1'h0,2'h0,8'h00,8'h00,8'h00,3'h4,16'h20F0,1'h0,1'h0},
        '{4'h7,1'h1,1'h0,2'h0,8'h00,8'h00,8'h00,3'h4,16'h20F0,1'h1,1'h0},
        '{4'h8,1'h0,1'h0,2'h0,8'h00,8'h00,8'h00,3'h4,16'h1324,1'h0,1'h1},
        '{4'hF,1'h0,1'h0,2'h0,8'h00,8'h00,8'h00,3'h0,16'h0000,1'h1,1'h0}};
    status_addr uut (.SYS_CLK, .RESET, .ACC, .DATA_POINTER, .PROG_COUNTER,
        .STACK_POINTER, .PSW_WR, .PSW_WDATA, .FLAG_UPD, .BOOL_CARRY_WR,
        .BOOL_CARRY, .ADDR_REQ, .PROGRAM_STATUS_WORD, .BANK, .ADDR_RESP);
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic drive(input row_s r);
        ADDR_REQ <= '{1'h1, status_addr_pkg::addr_mode_e'(r.md), r.wr,
            r.ex, status_addr_pkg::ptr_sel_e'(r.ps), r.op, r.fd, r.pv};
    endtask : drive
    task automatic req(input row_s r);
        @(posedge SYS_CLK);
        drive(r);
        @(posedge SYS_CLK);
        #1;
    endtask : req
    task automatic wr_psw(input logic [7:0] d);
        @(posedge SYS_CLK);
        PSW_WR <= 1'h1;
        PSW_WDATA <= d;
        @(posedge SYS_CLK);
        PSW_WR <= 1'h0;
        #1;
    endtask : wr_psw
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    initial begin
        SYS_CLK = 1'h0;
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        #20000;
        fail_count++;
        wrap_up();
    end
    initial begin
        {RESET, ACC, PSW_WR, PSW_WDATA} = {1'h1, 8'h00, 1'h0, 8'h00};
        {DATA_POINTER, PROG_COUNTER, STACK_POINTER} = 40'h1234_2000_47;
        {FLAG_UPD, BOOL_CARRY_WR, BOOL_CARRY, ADDR_REQ} = '0;
        repeat (3) @(posedge SYS_CLK);
        RESET <= 1'h0;
        wr_psw(8'h10);
        @(posedge SYS_CLK) ACC <= 8'hF0;
        foreach (rows[i]) begin
            req(rows[i]);
            chk(ADDR_RESP.valid, 1'h1);
            chk(ADDR_RESP.refused, rows[i].rf);
            chk(ADDR_RESP.write, rows[i].wr & ~rows[i].rf);
            chk(ADDR_RESP.jump, rows[i].jp);
            chk(ADDR_RESP.addr, rows[i].ad);
            chk(ADDR_RESP.space, rows[i].sp);
        end
        @(posedge SYS_CLK) ADDR_REQ <= '0;
        $display("address table done");
        for (int i = 0; i < 9; i++) begin
            @(posedge SYS_CLK) ACC <= 8'hFF >> i;
            wr_psw(8'h03);
            chk(PROGRAM_STATUS_WORD[1:0], {1'h0, i[0]});
        end
        for (int b = 0; b < 4; b++) begin
            wr_psw({3'h0, b[1:0], 3'h0});
            chk(BANK, b[1:0]);
            q = '0;
            q.md = 4'h3;
            q.op = 8'h07;
            req(q);
            chk(ADDR_RESP.addr, {11'h000, b[1:0], 3'h7});
        end
        q.op = 8'h02;
        @(posedge SYS_CLK);
        PSW_WR <= 1'h1;
        PSW_WDATA <= 8'h00;
        drive(q);
        @(posedge SYS_CLK);
        PSW_WR <= 1'h0;
        #1;
        chk(ADDR_RESP.addr, 16'h001A);
        req(q);
        chk(ADDR_RESP.addr, 16'h0002);
        @(posedge SYS_CLK) ADDR_REQ <= '0;
        wr_psw(8'hFC);
        chk(PROGRAM_STATUS_WORD, 8'hFC);
        wr_psw(8'h20);
        chk(PROGRAM_STATUS_WORD, 8'h20);
        @(posedge SYS_CLK);
        {PSW_WR, PSW_WDATA, BOOL_CARRY_WR, BOOL_CARRY} <= 11'h603;
        FLAG_UPD <= 6'b101111;
        @(posedge SYS_CLK);
        {PSW_WR, BOOL_CARRY_WR, FLAG_UPD} <= '0;
        #1;
        chk(PROGRAM_STATUS_WORD, 8'hC4);
        $display("status word tests done");
        wr_psw(8'hD8);
        req(q);
        chk(ADDR_RESP.addr, 16'h001A);
        @(posedge SYS_CLK) RESET <= 1'h1;
        @(posedge SYS_CLK) RESET <= 1'h0;
        #1;
        chk(PROGRAM_STATUS_WORD, 8'h00);
        chk(BANK, 2'h0);
        chk(ADDR_RESP.valid, 1'h0);
        @(posedge SYS_CLK);
        #1;
        chk(ADDR_RESP.valid, 1'h1);
        chk(ADDR_RESP.addr, 16'h0002);
        @(posedge SYS_CLK) ADDR_REQ <= '0;
        $display("reset test done");
        wrap_up();
    end
endmodule : tb_status_addr
bind status_addr status_addr_checker chk_i (.SYS_CLK, .RESET, .ACC,
    .DATA_POINTER, .PSW_WR, .PSW_WDATA, .FLAG_UPD, .BOOL_CARRY_WR,
    .BOOL_CARRY, .ADDR_REQ, .PROGRAM_STATUS_WORD, .BANK, .ADDR_RESP);
`default_nettype wire
